/* File: hdl/gate_select_pkg.sv */
// Constants and types for the logic cell input gating stage
`default_nettype none
package gate_select_pkg;
    localparam int LANES = 4;
    localparam int GATES = 3;
    localparam int CODE_W = 6;
    localparam int SOURCES = 64;
    localparam int ADDR_W = 16;
    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_STATUS = 12'h0e26;
    localparam logic [11:0] IDX_GATE_INVERT = 12'h0e28;
    localparam logic [11:0] IDX_LANE1_SOURCE_SELECT = 12'h0e29;
    localparam logic [11:0] IDX_LANE2_SOURCE_SELECT = 12'h0e2a;
    localparam logic [11:0] IDX_LANE3_SOURCE_SELECT = 12'h0e2b;
    localparam logic [11:0] IDX_LANE4_SOURCE_SELECT = 12'h0e2c;
    localparam logic [11:0] IDX_GATE1_TERM_SELECT = 12'h0e2d;
    localparam logic [11:0] IDX_GATE2_TERM_SELECT = 12'h0e2e;
    localparam logic [11:0] IDX_GATE3_TERM_SELECT = 12'h0e2f;
    localparam int IDX_SHIFT = 2;
    // Field positions
    localparam int CODE_LSB = 0;
    localparam int INVERT_LSB = 0;
    localparam int STATUS_LANE_LSB = 0;
    localparam int STATUS_GATE_LSB = 4;
    // Values after reset of the bus side, of the source stages and of the outputs
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [3:0] RESET_LANES = 4'h0;
    localparam logic [2:0] RESET_GATES = 3'h0;
    localparam logic [63:0] RESET_SOURCES = 64'h0000_0000_0000_0000;

    typedef struct packed {
        logic [LANES-1:0][CODE_W-1:0] lane_source_code;
        logic [GATES-1:0][7:0] gate_term_select;
        logic [GATES-1:0] gate_output_invert;
    } cell_config_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage
`default_nettype wire

/* File: hdl/logic_cell_input_gating.sv */
// Input lane selection and gate term selection of one configurable logic cell
// Behaviour
// - A 6-bit read/write code in bits 5:0 of the first select register picks lane 1's source.
// - A 6-bit read/write code in bits 5:0 of the second select register picks lane 2's source.
// - A 6-bit read/write code in bits 5:0 of the third select register picks lane 3's source.
// - A 6-bit read/write code in bits 5:0 of the fourth select register picks lane 4's source.
// - Lane codes are undefined after power-up and keep their value over any other reset.
// - Gate term bits are undefined after power-up and keep their value over any other reset.
// - In the gate 1 register bits 1, 3, 5, 7 include the true form of lanes 1 to 4.
// - In the gate 1 register bits 0, 2, 4, 6 include the inverted form of lanes 1 to 4.
// - The gate 2 register has the same layout, a set bit including its term in gate 2.
// - The gate 3 register has the same layout, a set bit including its term in gate 3.
// - A per-gate invert control inverts the gate output when set and passes it when clear.
`default_nettype none
module logic_cell_input_gating (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] source_in,
    output logic [3:0] lane_data,
    output logic [2:0] gate_out
);
    gate_select_pkg::apb_req_t req;
    gate_select_pkg::cell_config_t cfg;
    logic [gate_select_pkg::CODE_W-1:0] lane_code [gate_select_pkg::LANES];
    logic [7:0] term_sel [gate_select_pkg::GATES];
    logic invert_sel [gate_select_pkg::GATES];
    logic [63:0] src_s1;
    logic [63:0] src_s2;
    logic [63:0] src_s3;
    logic [63:0] src_stable;
    logic [11:0] reg_index;
    logic word_aligned;
    logic setup_phase;
    logic access_phase;
    logic rd_setup;
    logic sel_status;
    logic sel_invert;
    logic [3:0] sel_lane;
    logic [2:0] sel_gate;
    logic mapped;
    logic wr_fire;
    logic [31:0] rd_lane [gate_select_pkg::LANES];
    logic [31:0] rd_gate [gate_select_pkg::GATES];
    logic [31:0] rd_invert;
    logic [31:0] rd_status;
    logic [31:0] rd_word;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic [3:0] next_lane_data;
    logic [7:0] lane_terms;
    logic [2:0] gate_raw;
    logic [2:0] next_gate_out;

    assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

    // Configuration gathered into one carrier
    assign cfg = '{
        lane_source_code: {lane_code[3], lane_code[2], lane_code[1], lane_code[0]},
        gate_term_select: {term_sel[2], term_sel[1], term_sel[0]},
        gate_output_invert: {invert_sel[2], invert_sel[1], invert_sel[0]}
    };

    // Address decode
    assign reg_index = req.paddr[gate_select_pkg::IDX_SHIFT +: 12];
    assign word_aligned = (req.paddr[1:0] == 2'h0);
    assign sel_status = word_aligned && (reg_index == gate_select_pkg::IDX_STATUS);
    assign sel_invert = word_aligned && (reg_index == gate_select_pkg::IDX_GATE_INVERT);
    assign sel_lane[0] = word_aligned && (reg_index == gate_select_pkg::IDX_LANE1_SOURCE_SELECT);
    assign sel_lane[1] = word_aligned && (reg_index == gate_select_pkg::IDX_LANE2_SOURCE_SELECT);
    assign sel_lane[2] = word_aligned && (reg_index == gate_select_pkg::IDX_LANE3_SOURCE_SELECT);
    assign sel_lane[3] = word_aligned && (reg_index == gate_select_pkg::IDX_LANE4_SOURCE_SELECT);
    assign sel_gate[0] = word_aligned && (reg_index == gate_select_pkg::IDX_GATE1_TERM_SELECT);
    assign sel_gate[1] = word_aligned && (reg_index == gate_select_pkg::IDX_GATE2_TERM_SELECT);
    assign sel_gate[2] = word_aligned && (reg_index == gate_select_pkg::IDX_GATE3_TERM_SELECT);
    assign mapped = sel_status || sel_invert || (|sel_lane) || (|sel_gate);
    assign setup_phase = req.psel && !req.penable;
    assign access_phase = req.psel && req.penable;
    assign rd_setup = setup_phase && !req.pwrite;
    assign wr_fire = access_phase && req.pwrite && pready && !pslverr;

    // Read words per register, unused bits read as zero
    genvar i;
    generate
        for (i = 0; i < gate_select_pkg::LANES; i++) begin : g_lane_word
            assign rd_lane[i] = {26'h0, lane_code[i]};
        end
        for (i = 0; i < gate_select_pkg::GATES; i++) begin : g_gate_word
            assign rd_gate[i] = {24'h0, term_sel[i]};
        end
    endgenerate
    assign rd_invert = {29'h0, cfg.gate_output_invert};
    assign rd_status = {25'h0, gate_out, lane_data};

    // Read data selection
    assign rd_word =
        sel_lane[0] ? rd_lane[0] :
        sel_lane[1] ? rd_lane[1] :
        sel_lane[2] ? rd_lane[2] :
        sel_lane[3] ? rd_lane[3] :
        sel_gate[0] ? rd_gate[0] :
        sel_gate[1] ? rd_gate[1] :
        sel_gate[2] ? rd_gate[2] :
        sel_invert ? rd_invert :
        sel_status ? rd_status :
        gate_select_pkg::RESET_WORD;

    // Bus answer: ready one cycle after setup, error on an unmapped address
    assign next_pready = setup_phase;
    assign next_pslverr = setup_phase && !mapped;
    assign next_prdata = rd_setup ? rd_word : prdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= gate_select_pkg::RESET_WORD;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // Configuration keeps its value over reset and starts undefined
    generate
        for (i = 0; i < gate_select_pkg::LANES; i++) begin : g_lane_reg
            always_ff @(posedge pclk) begin
                if (wr_fire && sel_lane[i]) begin
                    lane_code[i] <= req.pwdata[gate_select_pkg::CODE_LSB +: gate_select_pkg::CODE_W];
                end
            end
        end
        for (i = 0; i < gate_select_pkg::GATES; i++) begin : g_gate_reg
            always_ff @(posedge pclk) begin
                if (wr_fire && sel_gate[i]) begin
                    term_sel[i] <= req.pwdata[7:0];
                end
            end
        end
        for (i = 0; i < gate_select_pkg::GATES; i++) begin : g_invert_reg
            always_ff @(posedge pclk) begin
                if (wr_fire && sel_invert) begin
                    invert_sel[i] <= req.pwdata[gate_select_pkg::INVERT_LSB + i];
                end
            end
        end
    endgenerate

    // Source inputs: three stages, a change counts when the last two agree
    generate
        for (i = 0; i < gate_select_pkg::SOURCES; i++) begin : g_src_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_s1[i] <= 1'b0;
                    src_s2[i] <= 1'b0;
                    src_s3[i] <= 1'b0;
                    src_stable[i] <= 1'b0;
                end else begin
                    src_s1[i] <= source_in[i];
                    src_s2[i] <= src_s1[i];
                    src_s3[i] <= src_s2[i];
                    if (src_s2[i] == src_s3[i]) begin
                        src_stable[i] <= src_s3[i];
                    end
                end
            end
        end
    endgenerate

    // Lane selection and gate terms
    generate
        for (i = 0; i < gate_select_pkg::LANES; i++) begin : g_lane_mux
            assign next_lane_data[i] = src_stable[cfg.lane_source_code[i]];
        end
        for (i = 0; i < gate_select_pkg::LANES; i++) begin : g_lane_term
            assign lane_terms[2*i+1] = next_lane_data[i];
            assign lane_terms[2*i] = ~next_lane_data[i];
        end
        for (i = 0; i < gate_select_pkg::GATES; i++) begin : g_gate
            assign gate_raw[i] = |(lane_terms & term_sel[i]);
            assign next_gate_out[i] = gate_raw[i] ^ cfg.gate_output_invert[i];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_data <= gate_select_pkg::RESET_LANES;
            gate_out <= gate_select_pkg::RESET_GATES;
        end else begin
            lane_data <= next_lane_data;
            gate_out <= next_gate_out;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/logic_cell_input_gating_bench.sv */
// Self-checking bench of the input gating stage
`default_nettype none
module logic_cell_input_gating_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] cfg [8];
    logic [63:0] source_in;
    logic [3:0] lane_data;
    logic [2:0] gate_out;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic_cell_input_gating uut (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .source_in(source_in),
        .lane_data(lane_data),
        .gate_out(gate_out)
    );
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [11:0] a(int i);
        return i < 7 ? 12'h0e29 + 12'(i) : 12'h0e28;
    endfunction
    function automatic logic [31:0] model();
        logic [7:0] t;
        logic [6:0] o;
        for (int k = 0; k < 4; k++) begin
            o[k] = source_in[cfg[k][5:0]];
            t[2*k+:2] = {o[k], ~o[k]};
        end
        for (int k = 0; k < 3; k++) o[4+k] = |(cfg[4+k][7:0] & t) ^ cfg[7][k];
        return {25'h0, o};
    endfunction
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        source_in = 64'h0123_4567_89ab_cdef;
        void'($urandom(32'h1613));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 24; r++) begin
            for (int i = 0; i < 8; i++) begin
                cfg[i] = r == 0 && i > 3 ? 32'h0 : $urandom & (i < 4 ? 32'h3f : i < 7 ? 32'hff : 32'h7);
                apb(1'b1, a(i), cfg[i]);
            end
            source_in <= r == 1 ? '1 : r == 2 ? '0 : {$urandom, $urandom};
            repeat (7) @(posedge pclk);
            check({25'h0, gate_out, lane_data}, model());
            if (r == 9) begin
                presetn <= 1'b0;
                @(posedge pclk);
                presetn <= 1'b1;
            end
            for (int i = 0; i < 8; i++) begin
                apb(1'b0, a(i), 32'h0);
                check(q, cfg[i]);
            end
        end
        apb(1'b0, 12'h0, 32'h0);
        check({31'h0, e}, 32'h1);
        conclude();
    end
endmodule
`default_nettype wire

/* File: testbench/logic_cell_input_gating_props.sv */
// Port checker of the input gating stage
`default_nettype none
module logic_cell_input_gating_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [63:0] source_in,
    input wire logic [3:0] lane_data,
    input wire logic [2:0] gate_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic setup = psel && !penable;
    wire logic lane_reg = paddr[15:2] inside {[14'h0e29:14'h0e2c]} && paddr[1:0] == 2'h0;
    wire logic gate_reg = paddr[15:2] inside {[14'h0e2d:14'h0e2f]} && paddr[1:0] == 2'h0;
    property p_ready; setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_lone; pready |-> $past(setup); endproperty
    a_lone: assert property (p_lone) else $error("stray ready");
    property p_lane_w; setup && lane_reg && !pwrite |=> prdata[31:6] == 26'h0; endproperty
    a_lane_w: assert property (p_lane_w) else $error("lane width");
    property p_gate_w; setup && gate_reg && !pwrite |=> prdata[31:8] == 24'h0; endproperty
    a_gate_w: assert property (p_gate_w) else $error("gate width");
    property p_ok; setup && (lane_reg || gate_reg) |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("bad error");
    property p_bad; setup && paddr == 16'h0000 |=> pslverr; endproperty
    a_bad: assert property (p_bad) else $error("no error");
    property p_high; (source_in == '1) [*6] |-> lane_data == 4'hf; endproperty
    a_high: assert property (p_high) else $error("lanes high");
    property p_low; (source_in == '0) [*6] |-> lane_data == 4'h0; endproperty
    a_low: assert property (p_low) else $error("lanes low");
endmodule
bind logic_cell_input_gating logic_cell_input_gating_props chk (.*);
`default_nettype wire
